// File: design/adc_control_sequencer.v
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"

module adc_control_sequencer (
  // Clock and reset
  input  wire        CLK_IN,
  input  wire        RST_B_IN,
  // APB slave
  input  wire        PSEL_IN,
  input  wire        PENABLE_IN,
  input  wire        PWRITE_IN,
  input  wire [7:0]  PADDR_IN,
  input  wire [31:0] PWDATA_IN,
  output wire        PREADY_OUT,
  output wire        PSLVERR_OUT,
  output wire [31:0] PRDATA_OUT,
  // Converter core
  input  wire [11:0] CORE_RESULT_IN,
  output wire        CORE_POWER_OUT,
  output wire        CORE_RESET_OUT,
  output wire        CORE_SAMPLE_OUT,
  output wire        CORE_CONVERT_OUT,
  output wire        CORE_CLK_TICK_OUT,
  output wire [12:0] CORE_INPUT_SEL_OUT,
  output wire        CORE_REF_EXTERNAL_OUT,
  // Interrupt controller
  input  wire        IRQ_ENABLE_IN,
  output wire        IRQ_REQUEST_FLAG_OUT,
  output wire        IRQ_SIGNAL_OUT,
  // Pin sharing
  input  wire [7:0]  PIN_ANALOG_SEL_IN,
  input  wire [7:0]  PIN_PULLUP_REQ_IN,
  output wire [7:0]  PIN_DIGITAL_EN_OUT,
  output wire [7:0]  PIN_PULLUP_EN_OUT
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam ST_IDLE    = 2'b00;
  localparam ST_HOLD    = 2'b01;
  localparam ST_SAMPLE  = 2'b10;
  localparam ST_CONVERT = 2'b11;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [4:0]  tick_count_q;
  reg  [4:0]  tick_count_d;
  reg         start_q;
  reg         start_prev_q;
  reg         running_q;
  reg         running_d;
  reg         enable_q;
  reg         align_q;
  reg  [3:0]  channel_q;
  reg  [1:0]  ref_sel_q;
  reg  [2:0]  div_sel_q;
  reg  [11:0] result_q;
  reg         done_q;
  reg         done_d;
  reg  [31:0] prdata_q;
  reg  [12:0] input_sel;
  reg  [7:0]  rd_data;
  reg         addr_hit;

  wire        wr_access;
  wire        setup_phase;
  wire        start_rise;
  wire        conv_tick;
  wire        div_restart;
  wire [7:0]  control_main;
  wire [7:0]  clock_ref;
  wire [7:0]  result_high;
  wire [7:0]  result_low;

  // ****************************************
  // APB access decode
  // ****************************************
  assign setup_phase = PSEL_IN && !PENABLE_IN;
  assign wr_access   = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !addr_hit;
  assign PRDATA_OUT  = prdata_q;

  assign control_main = {start_q, running_q, enable_q, align_q, channel_q};
  assign clock_ref    = {3'b000, ref_sel_q, div_sel_q};

  // Result formatting by alignment
  assign result_high = align_q ? {4'h0, result_q[11:8]} : result_q[11:4];
  assign result_low  = align_q ? result_q[7:0] : {result_q[3:0], 4'h0};

  always @* begin
    addr_hit = 1'b1;
    rd_data  = 8'h00;
    case (PADDR_IN)
      `ADDR_CONTROL_MAIN: begin
        rd_data = control_main;
      end
      `ADDR_CONTROL_CLOCK_REF: begin
        rd_data = clock_ref;
      end
      `ADDR_RESULT_HIGH: begin
        rd_data = result_high;
      end
      `ADDR_RESULT_LOW: begin
        rd_data = result_low;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // Read data captured in the setup phase, held through the access phase
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_phase && !PWRITE_IN) begin
      prdata_q <= {24'h00_0000, rd_data};
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      start_q   <= 1'b0;
      enable_q  <= 1'b0;
      align_q   <= 1'b0;
      channel_q <= 4'h0;
      ref_sel_q <= 2'b00;
      div_sel_q <= 3'b000;
    end else if (wr_access) begin
      if (PADDR_IN == `ADDR_CONTROL_MAIN) begin
        start_q   <= PWDATA_IN[`BIT_START];
        enable_q  <= PWDATA_IN[`BIT_ENABLE];
        align_q   <= PWDATA_IN[`BIT_ALIGN];
        channel_q <= PWDATA_IN[`CHAN_MSB:`CHAN_LSB];
      end
      if (PADDR_IN == `ADDR_CONTROL_CLOCK_REF) begin
        ref_sel_q <= PWDATA_IN[`REF_MSB:`REF_LSB];
        div_sel_q <= PWDATA_IN[`DIV_MSB:`DIV_LSB];
      end
    end
  end

  // ****************************************
  // Conversion clock divider
  // ****************************************
  assign div_restart = (state_q == ST_HOLD) || (state_q == ST_IDLE);

  conv_clock_divider i_conv_clock_divider (
    .CLK_IN     (CLK_IN),
    .RST_B_IN   (RST_B_IN),
    .DIV_SEL_IN (div_sel_q),
    .RESTART_IN (div_restart),
    .TICK_OUT   (conv_tick)
  );

  // ****************************************
  // Conversion sequencer
  // ****************************************
  assign start_rise = start_q && !start_prev_q;

  always @* begin
    state_d      = state_q;
    tick_count_d = tick_count_q;
    running_d    = running_q;
    done_d       = 1'b0;
    if (!enable_q) begin
      // Powered off converter cannot finish a conversion
      state_d      = ST_IDLE;
      tick_count_d = 5'h00;
      if (state_q != ST_IDLE) begin
        running_d = 1'b0;
      end
    end else if (start_rise) begin
      state_d      = ST_HOLD;
      tick_count_d = 5'h00;
      running_d    = 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_d = ST_IDLE;
        end
        ST_HOLD: begin
          running_d = 1'b1;
          if (!start_q) begin
            state_d = ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (conv_tick) begin
            if (tick_count_q == `SAMPLE_CLOCKS - 5'h01) begin
              state_d = ST_CONVERT;
            end
            tick_count_d = tick_count_q + 5'h01;
          end
        end
        ST_CONVERT: begin
          if (conv_tick) begin
            if (tick_count_q == `TOTAL_CLOCKS - 5'h01) begin
              state_d      = ST_IDLE;
              tick_count_d = 5'h00;
              running_d    = 1'b0;
              done_d       = 1'b1;
            end else begin
              tick_count_d = tick_count_q + 5'h01;
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_q      <= ST_IDLE;
      tick_count_q <= 5'h00;
      start_prev_q <= 1'b0;
      running_q    <= 1'b1;
      done_q       <= 1'b0;
      result_q     <= 12'h000;
    end else begin
      state_q      <= state_d;
      tick_count_q <= tick_count_d;
      start_prev_q <= start_q;
      running_q    <= running_d;
      done_q       <= done_d;
      if (done_d) begin
        result_q <= CORE_RESULT_IN;
      end
    end
  end

  // ****************************************
  // Converter core control
  // ****************************************
  assign CORE_POWER_OUT        = enable_q;
  assign CORE_RESET_OUT        = (state_q == ST_HOLD) || start_rise;
  assign CORE_SAMPLE_OUT       = (state_q == ST_SAMPLE) && !start_rise;
  assign CORE_CONVERT_OUT      = (state_q == ST_CONVERT) && !start_rise;
  assign CORE_CLK_TICK_OUT     = conv_tick && enable_q;
  assign CORE_REF_EXTERNAL_OUT = (ref_sel_q == `REF_EXTERNAL);
  assign CORE_INPUT_SEL_OUT    = input_sel;

  // One-hot input select: bits 7..0 external, 12..8 internal sources
  always @* begin
    input_sel = 13'h0000;
    case (channel_q)
      `CHAN_AMP_ZERO: begin
        input_sel[8] = 1'b1;
      end
      `CHAN_AMP_ONE: begin
        input_sel[9] = 1'b1;
      end
      `CHAN_VOLT_DETECT: begin
        input_sel[10] = 1'b1;
      end
      `CHAN_OVERCURRENT: begin
        input_sel[11] = 1'b1;
      end
      `CHAN_BANDGAP: begin
        input_sel[12] = 1'b1;
      end
      default: begin
        if (!channel_q[3]) begin
          input_sel[channel_q[2:0]] = 1'b1;
        end else begin
          input_sel = 13'h0000;
        end
      end
    endcase
  end

  // ****************************************
  // Interrupt request
  // ****************************************
  assign IRQ_REQUEST_FLAG_OUT = done_q;
  assign IRQ_SIGNAL_OUT       = done_q && IRQ_ENABLE_IN;

  // ****************************************
  // Pin sharing
  // ****************************************
  genvar pin;
  generate
    for (pin = 0; pin < 8; pin = pin + 1) begin : g_pin
      assign PIN_DIGITAL_EN_OUT[pin] = !PIN_ANALOG_SEL_IN[pin];
      assign PIN_PULLUP_EN_OUT[pin]  = PIN_PULLUP_REQ_IN[pin] && !PIN_ANALOG_SEL_IN[pin];
    end
  endgenerate

endmodule // adc_control_sequencer

// File: design/adc_ctrl_defines.vh
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

// ****************************************
// Register byte addresses
// ****************************************
`define ADDR_CONTROL_MAIN      8'h00
`define ADDR_CONTROL_CLOCK_REF 8'h04
`define ADDR_RESULT_HIGH       8'h08
`define ADDR_RESULT_LOW        8'h0C

// ****************************************
// Field positions, control main
// ****************************************
`define BIT_START              7
`define BIT_RUNNING            6
`define BIT_ENABLE             5
`define BIT_ALIGN              4
`define CHAN_MSB               3
`define CHAN_LSB               0

// ****************************************
// Field positions, clock and reference
// ****************************************
`define REF_MSB                4
`define REF_LSB                3
`define DIV_MSB                2
`define DIV_LSB                0
`define REF_EXTERNAL           2'b01

// ****************************************
// Reset values
// ****************************************
`define RESET_CONTROL_MAIN     8'h40
`define RESET_CLOCK_REF        5'h00

// ****************************************
// Conversion timing in conversion clocks
// ****************************************
`define SAMPLE_CLOCKS          5'h04
`define CONVERT_CLOCKS         5'h0C
`define TOTAL_CLOCKS           5'h10

// ****************************************
// Recommended conversion clock period
// ****************************************
`define CLK_PERIOD_NS          100
`define TAD_MIN_NS             500
`define TAD_MAX_NS             10000
`define TAD_MIN_CYCLES         ((`TAD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TAD_MAX_CYCLES         (`TAD_MAX_NS / `CLK_PERIOD_NS)

// ****************************************
// Channel codes
// ****************************************
`define CHAN_AMP_ZERO          4'h8
`define CHAN_AMP_ONE           4'h9
`define CHAN_VOLT_DETECT       4'hA
`define CHAN_OVERCURRENT       4'hB
`define CHAN_BANDGAP           4'hF

`endif

// File: design/conv_clock_divider.v
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"

module conv_clock_divider (
  // Clock and reset
  input  wire       CLK_IN,
  input  wire       RST_B_IN,
  // Control
  input  wire [2:0] DIV_SEL_IN,
  input  wire       RESTART_IN,
  // Tick
  output wire       TICK_OUT
);

  reg  [6:0] count_q;
  wire [6:0] limit;

  // Divisor is two to the power of the select code
  assign limit    = (7'h01 << DIV_SEL_IN) - 7'h01;
  assign TICK_OUT = (count_q >= limit) && !RESTART_IN;

  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      count_q <= 7'h00;
    end else if (RESTART_IN || count_q >= limit) begin
      count_q <= 7'h00;
    end else begin
      count_q <= count_q + 7'h01;
    end
  end

endmodule // conv_clock_divider

// File: tb/adc_control_sequencer_sva.sv
`timescale 1ns/1ps
module adc_control_sequencer_sva (
  // Clock and reset
  input wire        CLK_IN,
  input wire        RST_B_IN,
  // Observed ports
  input wire        PSLVERR_OUT,
  input wire        CORE_RESET_OUT,
  input wire        CORE_SAMPLE_OUT,
  input wire        CORE_CONVERT_OUT,
  input wire        CORE_CLK_TICK_OUT,
  input wire [12:0] CORE_INPUT_SEL_OUT,
  input wire        IRQ_ENABLE_IN,
  input wire        IRQ_REQUEST_FLAG_OUT,
  input wire        IRQ_SIGNAL_OUT,
  input wire [7:0]  PIN_ANALOG_SEL_IN,
  input wire [7:0]  PIN_PULLUP_REQ_IN,
  input wire [7:0]  PIN_DIGITAL_EN_OUT,
  input wire [7:0]  PIN_PULLUP_EN_OUT
);
  // ****************************************
  // Tick count within one conversion
  // ****************************************
  logic [4:0] tick_q;
  logic [4:0] tick_d;
  assign tick_d = (CORE_SAMPLE_OUT | CORE_CONVERT_OUT) ?
                  tick_q + {4'h0, CORE_CLK_TICK_OUT} : 5'h00;
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) tick_q <= 5'h00;
    else tick_q <= tick_d;
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // ****************************************
  // Assertions
  // ****************************************
  AST_IRQ_GATE: assert property (IRQ_SIGNAL_OUT == (IRQ_REQUEST_FLAG_OUT && IRQ_ENABLE_IN))
    else $error("interrupt signal not gated flag");
  AST_IRQ_PULSE: assert property (IRQ_REQUEST_FLAG_OUT |=> !IRQ_REQUEST_FLAG_OUT)
    else $error("request flag pulse too long");
  AST_IRQ_AFTER_CONV: assert property (IRQ_REQUEST_FLAG_OUT |-> $past(CORE_CONVERT_OUT))
    else $error("request flag without conversion");
  AST_TOTAL_TICKS: assert property (IRQ_REQUEST_FLAG_OUT |-> tick_q == 5'h10)
    else $error("conversion tick total wrong");
  AST_SAMPLE_TICKS: assert property (
    $fell(CORE_SAMPLE_OUT) && CORE_CONVERT_OUT |-> tick_q == 5'h04)
    else $error("sampling tick count wrong");
  AST_HOLD_IDLE: assert property (
    CORE_RESET_OUT |-> !CORE_SAMPLE_OUT && !CORE_CONVERT_OUT)
    else $error("converter active during reset");
  AST_SEL_ONEHOT: assert property ($onehot0(CORE_INPUT_SEL_OUT))
    else $error("input select not one-hot");
  AST_PIN_DIGITAL: assert property (PIN_DIGITAL_EN_OUT == ~PIN_ANALOG_SEL_IN)
    else $error("digital function not removed");
  AST_PIN_PULLUP: assert property (
    PIN_PULLUP_EN_OUT == (PIN_PULLUP_REQ_IN & ~PIN_ANALOG_SEL_IN))
    else $error("pull-high not removed");
  // ****************************************
  // Covers
  // ****************************************
  COV_IRQ: cover property (IRQ_SIGNAL_OUT);
  COV_HOLD: cover property (CORE_RESET_OUT ##1 CORE_RESET_OUT);
  COV_ERR: cover property (PSLVERR_OUT);
endmodule // adc_control_sequencer_sva

bind adc_control_sequencer adc_control_sequencer_sva i_adc_control_sequencer_sva (
  .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .PSLVERR_OUT(PSLVERR_OUT),
  .CORE_RESET_OUT(CORE_RESET_OUT), .CORE_SAMPLE_OUT(CORE_SAMPLE_OUT),
  .CORE_CONVERT_OUT(CORE_CONVERT_OUT), .CORE_CLK_TICK_OUT(CORE_CLK_TICK_OUT),
  .CORE_INPUT_SEL_OUT(CORE_INPUT_SEL_OUT), .IRQ_ENABLE_IN(IRQ_ENABLE_IN),
  .IRQ_REQUEST_FLAG_OUT(IRQ_REQUEST_FLAG_OUT), .IRQ_SIGNAL_OUT(IRQ_SIGNAL_OUT),
  .PIN_ANALOG_SEL_IN(PIN_ANALOG_SEL_IN), .PIN_PULLUP_REQ_IN(PIN_PULLUP_REQ_IN),
  .PIN_DIGITAL_EN_OUT(PIN_DIGITAL_EN_OUT), .PIN_PULLUP_EN_OUT(PIN_PULLUP_EN_OUT));

// File: tb/adc_control_sequencer_test.sv
`timescale 1ns/1ps
module adc_control_sequencer_test;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, irq_en;
  logic        power, core_rst, sample, convert, tick, ref_ext, irq_flag, irq_sig;
  logic [7:0]  paddr, pin_an, pin_pu, pin_dig, pin_pull;
  logic [31:0] pwdata, prdata, q;
  logic [11:0] result;
  logic [12:0] sel;
  logic        e;
  int          n_errors, num_checks, cycles, len, k;

  adc_control_sequencer i_adc_control_sequencer (
    .CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .PRDATA_OUT(prdata), .CORE_RESULT_IN(result),
    .CORE_POWER_OUT(power), .CORE_RESET_OUT(core_rst), .CORE_SAMPLE_OUT(sample),
    .CORE_CONVERT_OUT(convert), .CORE_CLK_TICK_OUT(tick), .CORE_INPUT_SEL_OUT(sel),
    .CORE_REF_EXTERNAL_OUT(ref_ext), .IRQ_ENABLE_IN(irq_en),
    .IRQ_REQUEST_FLAG_OUT(irq_flag), .IRQ_SIGNAL_OUT(irq_sig),
    .PIN_ANALOG_SEL_IN(pin_an), .PIN_PULLUP_REQ_IN(pin_pu),
    .PIN_DIGITAL_EN_OUT(pin_dig), .PIN_PULLUP_EN_OUT(pin_pull));

  // ****************************************
  // Clock and timeout
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      $display("FAIL %0t timeout", $time);
      results();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(q, {24'h00_0000, exp});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    irq_en = 1'b0;
    pin_an = 8'h0F;
    pin_pu = 8'h33;
    result = 12'hABC;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h00, 8'h40);
    rd(8'h04, 8'h00);
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'h1F);
    chk(pin_dig, 8'hF0);
    chk(pin_pull, 8'h30);
    apb(1'b0, 8'h10, 8'h00);
    chk({q[30:0], e}, 32'h0000_0001);
    $display("test registers done");
    for (int r = 0; r < 4; r++) begin
      wr(8'h04, {3'h0, 2'(r), 3'h0});
      chk(ref_ext, r == 1);
    end
    for (int c = 0; c < 16; c++) begin
      wr(8'h00, {4'h2, 4'(c)});
      chk(sel, c < 12 ? 13'h0001 << c : (c == 15 ? 13'h1000 : 13'h0000));
    end
    chk(power, 1'b1);
    $display("test routing done");
    repeat (20) @(posedge clk);
    for (int d = 3; d < 7; d++) begin
      irq_en <= (d == 3);
      wr(8'h04, 8'(d));
      wr(8'h00, 8'hA0);
      rd(8'h00, 8'hE0);
      repeat (5) @(posedge clk);
      chk({core_rst, sample, convert}, 32'h0000_0004);
      wr(8'h00, 8'h20);
      k = 0;
      while (sample !== 1'b1 && k < 100) begin
        @(negedge clk);
        k++;
      end
      len = 0;
      while (irq_flag !== 1'b1 && len < 3000) begin
        @(negedge clk);
        len++;
      end
      chk(irq_sig, d == 3);
      chk(32'(len), 32'(16 << d));
      rd(8'h00, 8'h20);
    end
    $display("test conversion done");
    rd(8'h08, 8'hAB);
    rd(8'h0C, 8'hC0);
    wr(8'h00, 8'h30);
    rd(8'h08, 8'h0A);
    rd(8'h0C, 8'hBC);
    wr(8'h00, 8'hA0);
    wr(8'h00, 8'h20);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h00);
    rd(8'h08, 8'hAB);
    chk(power, 1'b0);
    $display("test format done");
    results();
  end
endmodule // adc_control_sequencer_test
